// >>> hw/link_byte_deserializer.sv
module link_byte_deserializer (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       srst,
	// link pins
	input  wire logic       linkClk,
	input  wire logic       linkData,
	input  wire logic       linkFrame,
	input  wire logic       resetPinN,
	// byte side
	output logic            byteValid,
	output logic            byteFirst,
	output logic [7:0]      byteData,
	output logic            frameEnd,
	output logic            resetPinSyncN
);
	import panel_pkg::*;

	// =============================================
	// synchronisers: the first stage feeds only the second
	logic [3:0] syncA_ff;
	logic [3:0] syncB_ff;
	logic [3:0] prev_ff;
	logic [7:0] shift_ff, nxt_shift;
	logic [2:0] bits_ff, nxt_bits;
	logic       first_ff, nxt_first;
	logic       valid_ff, nxt_valid;
	logic       isFirst_ff, nxt_isFirst;
	logic [7:0] data_ff, nxt_data;
	logic       end_ff, nxt_end;
	logic       clkRise;
	logic       frameFall;

	always_ff @(posedge clock) begin
		if (srst) begin
			// idle levels of the pins, so no false frame or clock edge follows reset
			syncA_ff <= 4'h2;
			syncB_ff <= 4'h2;
			prev_ff  <= 4'h2;
		end else begin
			syncA_ff <= {resetPinN, linkFrame, linkData, linkClk};
			syncB_ff <= syncA_ff;
			prev_ff  <= syncB_ff;
		end
	end

	assign clkRise   = syncB_ff[0] & ~prev_ff[0];
	assign frameFall = ~syncB_ff[2] & prev_ff[2];

	// =============================================
	// shifter, msb first; a partial byte at frame end is dropped
	always_comb begin
		nxt_shift   = shift_ff;
		nxt_bits    = bits_ff;
		nxt_first   = first_ff;
		nxt_valid   = 1'b0;
		nxt_isFirst = isFirst_ff;
		nxt_data    = data_ff;
		nxt_end     = frameFall;
		if (!syncB_ff[2]) begin
			nxt_bits  = 3'h0;
			nxt_first = 1'b1;
		end else if (clkRise) begin
			nxt_shift = {shift_ff[6:0], syncB_ff[1]};
			nxt_bits  = bits_ff + 3'h1;
			if (bits_ff == 3'h7) begin
				nxt_valid   = 1'b1;
				nxt_data    = {shift_ff[6:0], syncB_ff[1]};
				nxt_isFirst = first_ff;
				nxt_first   = 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			shift_ff   <= 8'h00;
			bits_ff    <= 3'h0;
			first_ff   <= 1'b1;
			valid_ff   <= 1'b0;
			isFirst_ff <= 1'b0;
			data_ff    <= 8'h00;
			end_ff     <= 1'b0;
		end else begin
			shift_ff   <= nxt_shift;
			bits_ff    <= nxt_bits;
			first_ff   <= nxt_first;
			valid_ff   <= nxt_valid;
			isFirst_ff <= nxt_isFirst;
			data_ff    <= nxt_data;
			end_ff     <= nxt_end;
		end
	end

	assign byteValid     = valid_ff;
	assign byteFirst     = isFirst_ff;
	assign byteData      = data_ff;
	assign frameEnd      = end_ff;
	assign resetPinSyncN = syncB_ff[3];
endmodule : link_byte_deserializer

// >>> hw/panel_pkg.sv
package panel_pkg;
	// =============================================
	// clock and timing
	localparam int CLK_PERIOD_NS   = 25;
	localparam int LINE_TIME_NS    = 5850;
	localparam int LINE_CYCLES     = (LINE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OTP_LOAD_US     = 1000;
	localparam int POWERON_US      = 10000;
	localparam int OTP_LOAD_CYCLES = (OTP_LOAD_US * 1000) / CLK_PERIOD_NS;
	localparam int POWERON_CYCLES  = (POWERON_US * 1000) / CLK_PERIOD_NS;
	localparam int TIMER_W         = 24;

	// =============================================
	// frame geometry in lines
	localparam int ACTIVE_LINES   = 1600;
	localparam int VFP_LINES      = 150;
	localparam int VBP_LINES      = 150;
	localparam int FRAME_LINES    = ACTIVE_LINES + VFP_LINES + VBP_LINES;
	localparam int TEAR_FIRST     = ACTIVE_LINES + VFP_LINES;
	localparam int LINE_W         = 11;

	// =============================================
	// link commands
	localparam logic [7:0] CMD_PAGE      = 8'hFF;
	localparam logic [7:0] CMD_RELOAD    = 8'hFB;
	localparam logic [7:0] RELOAD_KEY    = 8'h01;
	localparam logic [7:0] CMD_COL_WIN   = 8'h2A;
	localparam logic [7:0] CMD_ROW_WIN   = 8'h2B;
	localparam logic [7:0] CMD_TEAR_ON   = 8'h35;
	localparam logic [7:0] CMD_TEAR_OFF  = 8'h34;
	localparam logic [7:0] CMD_LANES     = 8'hBA;
	localparam logic [7:0] CMD_LINK_MODE = 8'hBB;
	localparam logic [7:0] CMD_BLANK     = 8'hE5;
	localparam logic [7:0] CMD_COMPRESS  = 8'hC0;
	localparam logic [7:0] CMD_HIGH_RATE = 8'hBE;
	localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;
	localparam logic [7:0] CMD_SLEEP_IN  = 8'h10;
	localparam logic [7:0] CMD_DISP_ON   = 8'h29;
	localparam logic [7:0] CMD_DISP_OFF  = 8'h28;
	localparam logic [7:0] CMD_DSTBY     = 8'h4F;
	localparam logic [7:0] DSTBY_KEY     = 8'h01;

	// =============================================
	// pages and paged registers
	localparam logic [7:0] PAGE_MAIN    = 8'h10;
	localparam logic [7:0] PAGE_SYNC    = 8'h25;
	localparam logic [7:0] PAGE_DELAY   = 8'h26;
	localparam logic [7:0] PAGE_TIMING  = 8'hD0;
	localparam logic [7:0] R_PIN_CONTROL_THREE  = 8'h62;
	localparam logic [7:0] R_SOUT_LO    = 8'h65;
	localparam logic [7:0] R_SOUT_HI    = 8'h66;
	localparam logic [7:0] R_SOUT_W     = 8'h67;
	localparam logic [7:0] R_VDLY_LO    = 8'h02;
	localparam logic [7:0] R_VDLY_HI    = 8'h03;
	localparam logic [7:0] R_TIMING     = 8'h05;

	// =============================================
	// link modes and blank fill
	localparam logic [7:0] MODE_VIDEO_BYPASS = 8'h03;
	localparam logic [7:0] MODE_COMMAND      = 8'h10;
	localparam logic [7:0] MODE_VIDEO_RAM    = 8'h13;
	localparam logic [7:0] FILL_RANDOM       = 8'h00;
	localparam logic [7:0] FILL_BLACK        = 8'h01;

	// =============================================
	// reset values
	localparam logic [7:0] RST_PAGE      = PAGE_MAIN;
	localparam logic [7:0] RST_LINK_MODE = MODE_VIDEO_RAM;
	localparam logic [7:0] RST_FILL      = FILL_RANDOM;

	// =============================================
	// software register offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CONFIG = 8'h08;
	localparam logic [7:0] REG_WINDOW = 8'h0C;
	localparam logic [7:0] REG_SYNC   = 8'h10;
	localparam logic [7:0] REG_DELAY  = 8'h14;
	localparam int CTRL_FORCE_BLACK = 0;
	localparam int CTRL_HOLD_CFG    = 1;

	typedef enum logic [2:0] {
		PWR_SLEEP = 3'b000,
		PWR_LOAD  = 3'b001,
		PWR_INIT  = 3'b010,
		PWR_AWAKE = 3'b011,
		PWR_DSTBY = 3'b100
	} pwr_e;
endpackage : panel_pkg

// >>> hw/panel_power_init_sequencer.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
module panel_power_init_sequencer #(
	parameter int         OTP_LOAD_CYC = panel_pkg::OTP_LOAD_CYCLES,
	parameter int         POWERON_CYC  = panel_pkg::POWERON_CYCLES,
	parameter logic [7:0] OTP_TRIM     = 8'h5A  // arbitrary value
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       srst,
	// link and panel pins
	input  wire logic       linkClk,
	input  wire logic       linkData,
	input  wire logic       linkFrame,
	input  wire logic       activeLowReset_n,
	output logic            tearingSyncOutput,
	output logic            backlightPulseOutput,
	// decoded panel state
	output logic            videoBypassRam,
	output logic            commandMode,
	output logic            videoWithRam,
	output logic            fillBlack,
	output logic            displayOn,
	// register port
	input  wire logic [7:0] regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic [31:0]     regRdata
);
	import panel_pkg::*;

	function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
		be16 = {hi, lo};
	endfunction : be16

	logic       byteValid, byteFirst, frameEnd, pinN;
	logic [7:0] byteData;

	link_byte_deserializer u_deser (
		.clock         (clock),
		.srst          (srst),
		.linkClk       (linkClk),
		.linkData      (linkData),
		.linkFrame     (linkFrame),
		.resetPinN     (activeLowReset_n),
		.byteValid     (byteValid),
		.byteFirst     (byteFirst),
		.byteData      (byteData),
		.frameEnd      (frameEnd),
		.resetPinSyncN (pinN)
	);

	// =============================================
	// command capture and execution
	pwr_e             pwr_ff, nxt_pwr;
	logic [TIMER_W-1:0] timer_ff, nxt_timer;
	logic [7:0]       cmd_ff, nxt_cmd;
	logic [7:0]       param_ff [4];
	logic [7:0]       nxt_param [4];
	logic [2:0]       pcnt_ff, nxt_pcnt;
	logic [7:0]       page_ff, nxt_page, mode_ff, nxt_mode, fill_ff, nxt_fill;
	logic [7:0]       lanes_ff, nxt_lanes, comp_ff, nxt_comp, trim_ff, nxt_trim;
	logic [7:0]       timing_ff, nxt_timing, soutW_ff, nxt_soutW, pinCtl_ff, nxt_pinCtl;
	logic [15:0]      colEnd_ff, nxt_colEnd, rowEnd_ff, nxt_rowEnd;
	logic [15:0]      sout_ff, nxt_sout, vdly_ff, nxt_vdly;
	logic             tearOn_ff, nxt_tearOn, dispOn_ff, nxt_dispOn, reload_ff, nxt_reload;
	logic [1:0]       ctrl_ff, nxt_ctrl;
	logic             cfgOk;

	assign cfgOk = ((pwr_ff == PWR_SLEEP) || (pwr_ff == PWR_AWAKE)) && !ctrl_ff[CTRL_HOLD_CFG];

	always_comb begin
		nxt_pwr = pwr_ff;  nxt_timer = timer_ff;  nxt_cmd = cmd_ff;  nxt_pcnt = pcnt_ff;
		nxt_param = param_ff;  nxt_page = page_ff;  nxt_mode = mode_ff;  nxt_fill = fill_ff;
		nxt_lanes = lanes_ff;  nxt_comp = comp_ff;  nxt_trim = trim_ff;
		nxt_timing = timing_ff;  nxt_soutW = soutW_ff;  nxt_pinCtl = pinCtl_ff;
		nxt_colEnd = colEnd_ff;  nxt_rowEnd = rowEnd_ff;  nxt_sout = sout_ff;
		nxt_vdly = vdly_ff;  nxt_tearOn = tearOn_ff;  nxt_dispOn = dispOn_ff;
		nxt_reload = reload_ff;
		nxt_ctrl = ctrl_ff;
		if (regWrite && regAddr == REG_CTRL) begin
			nxt_ctrl = regWdata[1:0];
		end
		if (byteValid) begin
			if (byteFirst) begin
				nxt_cmd  = byteData;
				nxt_pcnt = 3'h0;
			end else if (pcnt_ff < 3'h4) begin
				nxt_param[pcnt_ff[1:0]] = byteData;
				nxt_pcnt = pcnt_ff + 3'h1;
			end
		end
		unique case (pwr_ff)
			PWR_LOAD: begin
				nxt_timer = timer_ff + 1'b1;
				if (timer_ff == TIMER_W'(OTP_LOAD_CYC - 1)) begin
					nxt_trim  = OTP_TRIM;
					nxt_timer = '0;
					nxt_pwr   = PWR_INIT;
				end
			end
			PWR_INIT: begin
				nxt_timer = timer_ff + 1'b1;
				if (timer_ff == TIMER_W'(POWERON_CYC - 1)) begin
					nxt_timer = '0;
					nxt_pwr   = PWR_AWAKE;
				end
			end
			PWR_SLEEP, PWR_AWAKE, PWR_DSTBY: begin
				nxt_timer = '0;
			end
		endcase
		if (frameEnd && pwr_ff != PWR_DSTBY) begin
			if (cmd_ff == CMD_SLEEP_OUT && pwr_ff == PWR_SLEEP) begin
				nxt_pwr = PWR_LOAD;
			end else if (cmd_ff == CMD_SLEEP_IN) begin
				nxt_pwr    = PWR_SLEEP;
				nxt_dispOn = 1'b0;
			end else if (cmd_ff == CMD_DSTBY && param_ff[0] == DSTBY_KEY && pcnt_ff != 3'h0) begin
				nxt_pwr    = PWR_DSTBY;
				nxt_dispOn = 1'b0;
			end else if (cfgOk) begin
				// settings refused while loading or powering up
				unique case (cmd_ff)
					CMD_DISP_ON:  nxt_dispOn = 1'b1;
					CMD_DISP_OFF: nxt_dispOn = 1'b0;
					CMD_TEAR_ON:  nxt_tearOn = 1'b1;
					CMD_TEAR_OFF: nxt_tearOn = 1'b0;
					CMD_PAGE: begin
						nxt_page   = param_ff[0];
						nxt_reload = 1'b0;
					end
					CMD_RELOAD:   nxt_reload = (param_ff[0] == RELOAD_KEY);
					default: begin
						if (page_ff == PAGE_MAIN) begin
							unique case (cmd_ff)
								CMD_COL_WIN:   nxt_colEnd = be16(param_ff[2], param_ff[3]);
								CMD_ROW_WIN:   nxt_rowEnd = be16(param_ff[2], param_ff[3]);
								CMD_LANES:     nxt_lanes  = param_ff[0];
								CMD_LINK_MODE: nxt_mode   = param_ff[0];
								CMD_BLANK:     nxt_fill   = param_ff[0];
								CMD_COMPRESS:  nxt_comp   = param_ff[0];
								default: ;
							endcase
						end else if (page_ff == PAGE_SYNC) begin
							unique case (cmd_ff)
								R_PIN_CONTROL_THREE: nxt_pinCtl = param_ff[0];
								R_SOUT_LO:   nxt_sout   = {sout_ff[15:8], param_ff[0]};
								R_SOUT_HI:   nxt_sout   = {param_ff[0], sout_ff[7:0]};
								R_SOUT_W:    nxt_soutW  = param_ff[0];
								default: ;
							endcase
						end else if (page_ff == PAGE_DELAY) begin
							unique case (cmd_ff)
								R_VDLY_LO: nxt_vdly = {vdly_ff[15:8], param_ff[0]};
								R_VDLY_HI: nxt_vdly = {param_ff[0], vdly_ff[7:0]};
								default: ;
							endcase
						end else if (page_ff == PAGE_TIMING && cmd_ff == R_TIMING) begin
							nxt_timing = param_ff[0];
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst || !pinN) begin
			pwr_ff <= PWR_SLEEP;  timer_ff <= '0;  cmd_ff <= 8'h00;  pcnt_ff <= 3'h0;
			param_ff <= '{default: 8'h00};
			page_ff <= RST_PAGE;  mode_ff <= RST_LINK_MODE;  fill_ff <= RST_FILL;
			lanes_ff <= 8'h00;  comp_ff <= 8'h00;  trim_ff <= 8'h00;  timing_ff <= 8'h00;
			soutW_ff <= 8'h00;  pinCtl_ff <= 8'h00;  colEnd_ff <= 16'h0000;
			rowEnd_ff <= 16'h0000;  sout_ff <= 16'h0000;  vdly_ff <= 16'h0000;
			tearOn_ff <= 1'b0;  dispOn_ff <= 1'b0;  reload_ff <= 1'b0;
		end else begin
			pwr_ff <= nxt_pwr;  timer_ff <= nxt_timer;  cmd_ff <= nxt_cmd;  pcnt_ff <= nxt_pcnt;
			param_ff <= nxt_param;
			page_ff <= nxt_page;  mode_ff <= nxt_mode;  fill_ff <= nxt_fill;
			lanes_ff <= nxt_lanes;  comp_ff <= nxt_comp;  trim_ff <= nxt_trim;
			timing_ff <= nxt_timing;  soutW_ff <= nxt_soutW;  pinCtl_ff <= nxt_pinCtl;
			colEnd_ff <= nxt_colEnd;  rowEnd_ff <= nxt_rowEnd;  sout_ff <= nxt_sout;
			vdly_ff <= nxt_vdly;  tearOn_ff <= nxt_tearOn;  dispOn_ff <= nxt_dispOn;
			reload_ff <= nxt_reload;
		end
	end

	// software control survives the panel reset pin on purpose
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_ff <= 2'b00;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// =============================================
	// line and frame timing, runs only when awake
	logic [7:0]        lineCyc_ff, nxt_lineCyc;
	logic [LINE_W-1:0] line_ff, nxt_line;
	logic              tear_ff, nxt_tear, blPulse_ff, nxt_blPulse;
	logic [15:0]       lineWide;

	assign lineWide = {5'h00, line_ff};

	always_comb begin
		nxt_lineCyc = 8'h00;
		nxt_line    = '0;
		if (pwr_ff == PWR_AWAKE) begin
			nxt_lineCyc = lineCyc_ff + 8'h01;
			nxt_line    = line_ff;
			if (lineCyc_ff == 8'(LINE_CYCLES - 1)) begin
				nxt_lineCyc = 8'h00;
				nxt_line    = (line_ff == LINE_W'(FRAME_LINES - 1)) ? '0 : line_ff + 1'b1;
			end
		end
		// tear output marks the vertical back porch
		nxt_tear    = tearOn_ff && (pwr_ff == PWR_AWAKE) && (line_ff >= LINE_W'(TEAR_FIRST));
		nxt_blPulse = dispOn_ff && (pwr_ff == PWR_AWAKE) && (lineWide >= sout_ff)
			&& (lineWide < sout_ff + {8'h00, soutW_ff});
	end

	always_ff @(posedge clock) begin
		if (srst || !pinN) begin
			lineCyc_ff <= 8'h00;
			line_ff    <= '0;
			tear_ff    <= 1'b0;
			blPulse_ff <= 1'b0;
		end else begin
			lineCyc_ff <= nxt_lineCyc;
			line_ff    <= nxt_line;
			tear_ff    <= nxt_tear;
			blPulse_ff <= nxt_blPulse;
		end
	end

	assign tearingSyncOutput    = tear_ff;
	assign backlightPulseOutput = blPulse_ff;
	assign videoBypassRam = (mode_ff == MODE_VIDEO_BYPASS);
	assign commandMode    = (mode_ff == MODE_COMMAND);
	assign videoWithRam   = (mode_ff == MODE_VIDEO_RAM);
	// black fill, software may force it
	assign fillBlack      = (fill_ff == FILL_BLACK) || ctrl_ff[CTRL_FORCE_BLACK];
	assign displayOn      = dispOn_ff;

	// =============================================
	// register read port
	logic [31:0] rdata_ff, nxt_rdata;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (regRead) begin
			unique case (regAddr)
				REG_CTRL:   nxt_rdata = {30'h0, ctrl_ff};
				REG_STATUS: nxt_rdata = {trim_ff, 16'h0, 2'b00, reload_ff, tearOn_ff,
					dispOn_ff, pwr_ff};
				REG_CONFIG: nxt_rdata = {page_ff, mode_ff, lanes_ff, fill_ff};
				REG_WINDOW: nxt_rdata = {colEnd_ff, rowEnd_ff};
				REG_SYNC:   nxt_rdata = {pinCtl_ff, soutW_ff, sout_ff};
				REG_DELAY:  nxt_rdata = {vdly_ff, timing_ff, comp_ff};
				default:    nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign regRdata = rdata_ff;

	// =============================================
	// assertions
	a_sleep_out_load: assert property (@(posedge clock) disable iff (srst || !pinN)
		(frameEnd && cmd_ff == CMD_SLEEP_OUT && pwr_ff == PWR_SLEEP) |=> pwr_ff == PWR_LOAD)
		else $error("sleep exit did not start the reload");
	a_busy_blocks_cfg: assert property (@(posedge clock) disable iff (srst || !pinN)
		(frameEnd && cmd_ff == CMD_PAGE && (pwr_ff == PWR_LOAD || pwr_ff == PWR_INIT))
		|=> $stable(page_ff))
		else $error("setting taken while powering up");
	a_load_then_init: assert property (@(posedge clock) disable iff (srst || !pinN)
		(pwr_ff == PWR_LOAD && nxt_pwr == PWR_INIT) |=> (trim_ff == OTP_TRIM) ##1
		(pwr_ff == PWR_INIT))
		else $error("trim not loaded before power-up");
	a_tear_needs_on: assert property (@(posedge clock) disable iff (srst || !pinN)
		$rose(tear_ff) |-> $past(tearOn_ff) && $past(pwr_ff == PWR_AWAKE))
		else $error("tear output without enable");
	a_tear_holds: assert property (@(posedge clock) disable iff (srst || !pinN)
		($rose(tear_ff) && tearOn_ff && pwr_ff == PWR_AWAKE) |->
		##1 (tear_ff || !tearOn_ff || pwr_ff != PWR_AWAKE)[*8])
		else $error("tear pulse too short");
	a_mode_decode: assert property (@(posedge clock) disable iff (srst || !pinN)
		(frameEnd && cfgOk && cmd_ff == CMD_LINK_MODE && page_ff == PAGE_MAIN)
		|=> videoWithRam == ($past(param_ff[0]) == MODE_VIDEO_RAM))
		else $error("link mode decode wrong");
	a_fill_decode: assert property (@(posedge clock) disable iff (srst || !pinN)
		(frameEnd && cfgOk && cmd_ff == CMD_BLANK && page_ff == PAGE_MAIN && !ctrl_ff[0])
		|=> fillBlack == ($past(param_ff[0]) == FILL_BLACK))
		else $error("blank fill decode wrong");
	a_refuse_stby: assert property (@(posedge clock) disable iff (srst || !pinN)
		(pwr_ff == PWR_DSTBY) |=> pwr_ff == PWR_DSTBY)
		else $error("deep standby left without reset");

	c_awake: cover property (@(posedge clock) disable iff (srst) pwr_ff == PWR_AWAKE);
	c_tear:  cover property (@(posedge clock) disable iff (srst) $rose(tear_ff));
	c_disp:  cover property (@(posedge clock) disable iff (srst) $rose(dispOn_ff));
endmodule : panel_power_init_sequencer

// >>> verification/host_link_model.sv
module host_link_model (
	// link pins
	output logic linkClk,
	output logic linkData,
	output logic linkFrame,
	output logic activeLowReset_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// =============================================
	// idle pins
	// reset low, lanes in stop state
	initial begin
		linkClk = 1'b0;
		linkData = 1'b1;
		linkFrame = 1'b0;
		activeLowReset_n = 1'b0;
	end

	// =============================================
	// reset pin sequence
	// rise, fall, rise, waits rounded up
	task pulseReset();
		#10007 activeLowReset_n <= 1'b1;
		#10000 activeLowReset_n <= 1'b0;
		#10000 activeLowReset_n <= 1'b1;
		// settle wait shortened so the run stays brief
		#20000;
	endtask : pulseReset

	// =============================================
	// one packet, msb first
	// whole packet before the next one
	task sendPacket(input logic [39:0] bytes, input int n);
		// offset keeps link edges clear of the system clock edges
		#3 linkFrame <= 1'b1;
		for (int i = 0; i < n * 8; i++) begin
			linkData <= bytes[39 - i];
			#100 linkClk <= 1'b1;
			#100 linkClk <= 1'b0;
		end
		#100 linkFrame <= 1'b0;
		// released line must not keep showing the last bit
		linkData <= ~linkData;
		#200;
	endtask : sendPacket
endmodule : host_link_model

// >>> verification/panel_power_init_sequencer_tb.sv
module panel_power_init_sequencer_tb import panel_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int         LOAD_C = 400;
	localparam int         PWR_C  = 400;
	localparam logic [7:0] TRIM   = 8'h3C;  // arbitrary value

	logic        clock;
	logic        srst;
	logic        regWrite;
	logic        regRead;
	logic [7:0]  regAddr;
	logic [31:0] regWdata;
	logic [31:0] regRdata;
	logic [31:0] rd;
	logic        linkClk;
	logic        linkData;
	logic        linkFrame;
	logic        activeLowReset_n;
	logic        tearingSyncOutput;
	logic        backlightPulseOutput;
	logic        videoBypassRam;
	logic        commandMode;
	logic        videoWithRam;
	logic        fillBlack;
	logic        displayOn;
	int          mismatches;
	int          checksDone;
	int          i;
	logic [7:0]  modeTab [3];
	logic [2:0]  decTab  [3];

	host_link_model host (.linkClk, .linkData, .linkFrame, .activeLowReset_n);

	panel_power_init_sequencer #(.OTP_LOAD_CYC(LOAD_C), .POWERON_CYC(PWR_C), .OTP_TRIM(TRIM)) dut (
		.clock, .srst, .linkClk, .linkData, .linkFrame, .activeLowReset_n,
		.tearingSyncOutput, .backlightPulseOutput, .videoBypassRam, .commandMode,
		.videoWithRam, .fillBlack, .displayOn, .regAddr, .regWdata, .regWrite,
		.regRead, .regRdata
	);

	// =============================================
	// clock and watchdog
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		#2000000;
		mismatches++;
		close_out();
	end

	// =============================================
	// shared tasks
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : regWr

	task regRd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdata;
		@(posedge clock);
		#1 check("rdata idle", regRdata, 32'h0);
	endtask : regRd

	task cmd(input logic [39:0] b, input int n);
		host.sendPacket(b, n);
		repeat (4) @(posedge clock);
	endtask : cmd

	task close_out();
		$display("mismatches %0d checks %0d", mismatches, checksDone);
		if (mismatches == 0 && checksDone > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	// =============================================
	// main sequence
	initial begin
		srst = 1'b1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		mismatches = 0;
		checksDone = 0;
		modeTab = '{MODE_VIDEO_BYPASS, MODE_COMMAND, MODE_VIDEO_RAM};
		decTab = '{3'b100, 3'b010, 3'b001};
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		host.pulseReset();
		regRd(REG_CONFIG, rd);
		check("page", rd[31:24], PAGE_MAIN);
		check("fill", rd[7:0], FILL_RANDOM);
		check("ram mode", videoWithRam, 1'b1);
		regWr(8'h40, 32'hFFFFFFFF);
		regRd(8'h40, rd);
		check("unmapped", rd, 32'h0);
		regWr(REG_STATUS, 32'h00000007);
		regRd(REG_STATUS, rd);
		check("status ro", rd[2:0], PWR_SLEEP);
		for (i = 0; i < 3; i++) begin
			cmd({CMD_LINK_MODE, modeTab[i], 24'h0}, 2);
			check("mode decode", {videoBypassRam, commandMode, videoWithRam}, decTab[i]);
		end
		cmd({CMD_BLANK, FILL_BLACK, 24'h0}, 2);
		check("black", fillBlack, 1'b1);
		cmd({CMD_BLANK, FILL_RANDOM, 24'h0}, 2);
		check("random", fillBlack, 1'b0);
		regWr(REG_CTRL, 32'h00000001);
		check("force black", fillBlack, 1'b1);
		regWr(REG_CTRL, 32'h00000002);
		cmd({CMD_BLANK, FILL_BLACK, 24'h0}, 2);
		check("hold cfg", fillBlack, 1'b0);
		regWr(REG_CTRL, 32'h0);
		cmd({CMD_PAGE, PAGE_SYNC, 24'h0}, 2);
		regRd(REG_CONFIG, rd);
		check("page sel", rd[31:24], PAGE_SYNC);
		cmd({CMD_PAGE, PAGE_MAIN, 24'h0}, 2);
		cmd({CMD_RELOAD, RELOAD_KEY, 24'h0}, 2);
		cmd({CMD_COL_WIN, 32'h0000059F}, 5);
		cmd({CMD_ROW_WIN, 32'h0000063F}, 5);
		regRd(REG_WINDOW, rd);
		check("window", rd, 32'h059F063F);
		cmd({CMD_LANES, 8'h07, 24'h0}, 2);
		cmd({CMD_COMPRESS, 8'h83, 24'h0}, 2);
		cmd({CMD_HIGH_RATE, 32'h01900F39}, 5);
		regRd(REG_CONFIG, rd);
		check("lanes", rd[15:8], 8'h07);
		cmd({CMD_PAGE, PAGE_DELAY, 24'h0}, 2);
		cmd({CMD_RELOAD, RELOAD_KEY, 24'h0}, 2);
		cmd({R_VDLY_LO, 8'hC0, 24'h0}, 2);
		cmd({R_VDLY_HI, 8'h00, 24'h0}, 2);
		cmd({CMD_PAGE, PAGE_SYNC, 24'h0}, 2);
		cmd({CMD_RELOAD, RELOAD_KEY, 24'h0}, 2);
		cmd({R_PIN_CONTROL_THREE, 8'h60, 24'h0}, 2);
		cmd({R_SOUT_LO, 8'h00, 24'h0}, 2);
		cmd({R_SOUT_HI, 8'h07, 24'h0}, 2);
		cmd({R_SOUT_W, 8'h56, 24'h0}, 2);
		cmd({CMD_PAGE, PAGE_TIMING, 24'h0}, 2);
		cmd({CMD_RELOAD, RELOAD_KEY, 24'h0}, 2);
		cmd({R_TIMING, 8'h88, 24'h0}, 2);
		cmd({CMD_PAGE, PAGE_MAIN, 24'h0}, 2);
		cmd({CMD_RELOAD, RELOAD_KEY, 24'h0}, 2);
		regRd(REG_SYNC, rd);
		check("sync shape", rd, 32'h60560700);
		regRd(REG_DELAY, rd);
		check("delay timing", rd, 32'h00C08883);
		regRd(REG_STATUS, rd);
		check("reloaded", rd[5], 1'b1);
		cmd({CMD_TEAR_ON, 8'h00, 24'h0}, 2);
		regRd(REG_STATUS, rd);
		check("tear on", rd[4], 1'b1);
		check("tear asleep", tearingSyncOutput, 1'b0);
		cmd({CMD_SLEEP_OUT, 32'h0}, 1);
		regRd(REG_STATUS, rd);
		check("loading", rd[2:0], PWR_LOAD);
		cmd({CMD_LINK_MODE, MODE_COMMAND, 24'h0}, 2);
		check("load refuses", commandMode, 1'b0);
		for (i = 0; i < 400 && rd[2:0] !== PWR_AWAKE; i++) begin
			regRd(REG_STATUS, rd);
		end
		check("awake", rd[2:0], PWR_AWAKE);
		if (rd[2:0] !== PWR_AWAKE) begin
			close_out();
		end
		check("trim", rd[31:24], TRIM);
		cmd({CMD_DISP_ON, 32'h0}, 1);
		check("display on", displayOn, 1'b1);
		check("backlight", backlightPulseOutput, 1'b0);
		cmd({CMD_DISP_OFF, 32'h0}, 1);
		check("display off", displayOn, 1'b0);
		cmd({CMD_TEAR_OFF, 32'h0}, 1);
		cmd({CMD_SLEEP_IN, 32'h0}, 1);
		regRd(REG_STATUS, rd);
		check("tear off", rd[4], 1'b0);
		check("sleep in", rd[2:0], PWR_SLEEP);
		cmd({CMD_DSTBY, DSTBY_KEY, 24'h0}, 2);
		regRd(REG_STATUS, rd);
		check("standby", rd[2:0], PWR_DSTBY);
		cmd({CMD_BLANK, FILL_BLACK, 24'h0}, 2);
		check("standby refuses", fillBlack, 1'b0);
		regWr(REG_CTRL, 32'h00000001);
		host.pulseReset();
		regRd(REG_STATUS, rd);
		check("pin reset", rd[2:0], PWR_SLEEP);
		regRd(REG_CTRL, rd);
		check("ctrl kept", rd[0], 1'b1);
		close_out();
	end
endmodule : panel_power_init_sequencer_tb
